// ==== rtl/range_ctrl_pkg.sv ====
/*
 * Shared constants for the transfer case range and torque controller:
 * encoder codes, timing figures, speed limits and clutch duty figures.
 * Assumes a single system clock at the rate given by clk_hz.
 */
`default_nettype none
package range_ctrl_pkg;
   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned BULB_MS        = 600;
   localparam int unsigned BLINK_MS       = 300;
   localparam int unsigned NEUTRAL_MS     = 2000;
   localparam int unsigned SHIFT_MS       = 5000;
   localparam int unsigned RETRY_MS       = 3000;
   localparam int unsigned BULB_CYC       = BULB_MS * CYC_PER_MS;
   localparam int unsigned BLINK_CYC      = BLINK_MS * CYC_PER_MS;
   localparam int unsigned NEUTRAL_CYC    = NEUTRAL_MS * CYC_PER_MS;
   localparam int unsigned SHIFT_CYC      = SHIFT_MS * CYC_PER_MS;
   localparam int unsigned RETRY_CYC      = RETRY_MS * CYC_PER_MS;
   localparam int unsigned TIMER_W        = 26;
   // ***************************************************************
   // encoder codes, line 1 in bit 3
   // ***************************************************************
   localparam logic [3:0] ENC_LEFT_STOP   = 4'he;
   localparam logic [3:0] ENC_LEFT_HIGH   = 4'ha;
   localparam logic [3:0] ENC_HIGH        = 4'h2;
   localparam logic [3:0] ENC_RIGHT_HIGH  = 4'h0;
   localparam logic [3:0] ENC_NEUTRAL     = 4'h9;
   localparam logic [3:0] ENC_ZONE2       = 4'h1;
   localparam logic [3:0] ENC_LOW         = 4'h5;
   localparam logic [3:0] ENC_RIGHT_STOP  = 4'h4;
   // ***************************************************************
   // speed and clutch duty
   // ***************************************************************
   localparam int unsigned RPM_W          = 12;
   localparam logic [11:0] SHIFT_RPM_MAX  = 12'h057;
   localparam logic [11:0] LOW_RPM_MAX    = 12'h0af;
   localparam logic [11:0] SLIP_RPM_LIMIT = 12'h014;
   localparam logic [6:0]  DUTY_ABS       = 7'h1e;
   localparam logic [6:0]  DUTY_MAX       = 7'h58;
   localparam logic [6:0]  DUTY_STEP      = 7'h04;
   localparam logic [6:0]  PWM_STEPS      = 7'h64;
   localparam int unsigned PWM_TICK_CYC   = 10;

   function automatic logic enc_valid(input logic [3:0] c);
      return (c == ENC_LEFT_STOP) || (c == ENC_LEFT_HIGH) || (c == ENC_HIGH) ||
             (c == ENC_RIGHT_HIGH) || (c == ENC_NEUTRAL) || (c == ENC_ZONE2) ||
             (c == ENC_LOW) || (c == ENC_RIGHT_STOP);
   endfunction

   function automatic logic enc_high_side(input logic [3:0] c);
      return (c == ENC_LEFT_STOP) || (c == ENC_LEFT_HIGH) || (c == ENC_HIGH);
   endfunction

   function automatic logic enc_low_side(input logic [3:0] c);
      return (c == ENC_LOW) || (c == ENC_RIGHT_STOP);
   endfunction
endpackage
`default_nettype wire

// ==== rtl/transfer_range_shift_torque_ctrl.sv ====
/*
 * Range shift sequencer, indicator lamps and front clutch coil PWM.
 * Assumes all inputs synchronous to clk_i; speeds arrive as measured
 * propshaft rpm, throttle position already taken off the CAN bus.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: ignition on lights both lamps 0.6 s
// RULE_02: decode the eight encoder position codes
// RULE_03: codes outside the table are invalid
// RULE_04: matching position at power-up needs no action
// RULE_05: high selected, low side: blink, shift high
// RULE_06: low selected, high side: blink, shift low
// RULE_07: shift only with valid code at request
// RULE_08: drive until target code; invalid means default
// RULE_09: start on switch toggle or power-up mismatch
// RULE_10: diagnostic check fails, no shift attempted
// RULE_11: neutral 2 s and speeds below 87 rpm
// RULE_12: criteria lost suspends shift, keep blinking
// RULE_13: 5 s without arrival is a failed shift
// RULE_14: motor energized ignores vehicle inputs
// RULE_15: blink low lamp 0.3 s on/off
// RULE_16: success sets low lamp by final range
// RULE_17: default mode retries, then returns, inhibits
// RULE_18: second return fails or succeeds, fault lamp
// RULE_19: base clutch duty from speed and throttle
// RULE_20: slip raises duty, then back to base
// RULE_21: antilock braking holds duty at 30%
// RULE_22: low range above 175 rpm gives 88%
module transfer_range_shift_torque_ctrl
   import range_ctrl_pkg::*;
#(
   parameter int unsigned BULB_T    = BULB_CYC,
   parameter int unsigned BLINK_T   = BLINK_CYC,
   parameter int unsigned NEUTRAL_T = NEUTRAL_CYC,
   parameter int unsigned SHIFT_T   = SHIFT_CYC,
   parameter int unsigned RETRY_T   = RETRY_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              ignition_i,
   input  wire logic [3:0]        encoder_i,
   input  wire logic              range_select_switch_i,
   input  wire logic              neutral_i,
   input  wire logic [RPM_W-1:0]  front_rpm_i,
   input  wire logic [RPM_W-1:0]  rear_rpm_i,
   input  wire logic [7:0]        throttle_position_i,
   input  wire logic              antilock_brake_active_i,
   input  wire logic              motor_fault_i,
   input  wire logic              speed_sensor_fault_i,
   output logic                   motor_to_high_o,
   output logic                   motor_to_low_o,
   output logic                   low_range_lamp_o,
   output logic                   fault_lamp_o,
   output logic                   shift_inhibited_o,
   output logic                   front_clutch_coil_o
);
   // ***************************************************************
   // parameter checks
   // ***************************************************************
   if (BULB_T < 1 || BLINK_T < 1 || NEUTRAL_T < 1 || SHIFT_T < 1 || RETRY_T < 1 ||
       BULB_T >= 2**TIMER_W || SHIFT_T >= 2**TIMER_W || RETRY_T >= 2**TIMER_W ||
       NEUTRAL_T >= 2**TIMER_W || BLINK_T >= 2**TIMER_W) begin : g_bad
      $error("timing parameter out of range");
   end

   typedef enum logic [2:0] {
      ST_OFF, ST_BULB, ST_IDLE, ST_QUAL, ST_DRIVE, ST_WAIT
   } state_t;

   state_t             state;
   logic [TIMER_W-1:0] timer;
   logic [TIMER_W-1:0] blink_cnt;
   logic               blink_ph;
   logic               target_low;
   logic [1:0]         attempt;
   logic               sw_prev;
   logic               lamp_steady;
   logic               fault_lamp;
   logic               inhibit;
   logic               goal_low;
   logic               valid;
   logic               at_goal;
   logic               speeds_ok;
   logic               diag_ok;
   logic               blinking;

   // ***************************************************************
   // position decode
   // ***************************************************************
   assign valid     = enc_valid(encoder_i);                                   // [RULE_02] [RULE_03]
   assign goal_low  = attempt[1] ? ~target_low : target_low;
   assign at_goal   = goal_low ? (encoder_i == ENC_LOW) : (encoder_i == ENC_HIGH); // [RULE_08]
   assign speeds_ok = (front_rpm_i < SHIFT_RPM_MAX) && (rear_rpm_i < SHIFT_RPM_MAX); // [RULE_11]
   assign diag_ok   = valid && !motor_fault_i && !speed_sensor_fault_i;      // [RULE_10] [RULE_07]
   assign blinking  = (state == ST_QUAL) || (state == ST_DRIVE) || (state == ST_WAIT);

   // ***************************************************************
   // shift sequencer
   // ***************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state           <= ST_OFF;
         timer           <= '0;
         target_low      <= 1'b0;
         attempt         <= 2'h0;
         lamp_steady     <= 1'b0;
         fault_lamp      <= 1'b0;
         inhibit         <= 1'b0;
         motor_to_high_o <= 1'b0;
         motor_to_low_o  <= 1'b0;
      end else begin
         case (state)
            ST_OFF: begin
               inhibit         <= 1'b0;
               fault_lamp      <= 1'b0;
               motor_to_high_o <= 1'b0;
               motor_to_low_o  <= 1'b0;
               timer           <= '0;
               if (ignition_i) begin
                  state <= ST_BULB;
               end
            end
            ST_BULB: begin
               timer <= timer + 1'b1;
               if (!ignition_i) begin
                  state <= ST_OFF;
               end else if (timer == TIMER_W'(BULB_T - 1)) begin            // [RULE_01]
                  timer <= '0;
                  if (range_select_switch_i ? enc_low_side(encoder_i)
                                            : enc_high_side(encoder_i)) begin
                     lamp_steady <= range_select_switch_i;                   // [RULE_04]
                     state       <= ST_IDLE;
                  end else if (diag_ok) begin                                // [RULE_09]
                     target_low <= range_select_switch_i;                    // [RULE_05] [RULE_06]
                     attempt    <= 2'h0;
                     state      <= ST_QUAL;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               timer <= '0;
               if (!ignition_i) begin
                  state <= ST_OFF;
               end else if (range_select_switch_i != sw_prev && !inhibit) begin // [RULE_09]
                  if (diag_ok) begin                                         // [RULE_10] [RULE_07]
                     target_low <= range_select_switch_i;
                     attempt    <= 2'h0;
                     state      <= ST_QUAL;
                  end
               end
            end
            ST_QUAL: begin
               if (!ignition_i) begin
                  state <= ST_OFF;
               end else if (range_select_switch_i != target_low) begin       // [RULE_12]
                  state <= ST_IDLE;
               end else if (neutral_i && speeds_ok) begin
                  timer <= timer + 1'b1;
                  if (timer == TIMER_W'(NEUTRAL_T - 1)) begin                // [RULE_11]
                     timer <= '0;
                     state <= ST_DRIVE;
                  end
               end else begin
                  timer <= '0;                                               // [RULE_12]
               end
            end
            ST_DRIVE: begin
               // vehicle inputs are not looked at here [RULE_14]
               timer           <= timer + 1'b1;
               motor_to_low_o  <= goal_low;                                  // [RULE_13]
               motor_to_high_o <= ~goal_low;
               if (valid && at_goal) begin                                   // [RULE_08]
                  motor_to_high_o <= 1'b0;
                  motor_to_low_o  <= 1'b0;
                  timer           <= '0;
                  lamp_steady     <= goal_low;                               // [RULE_16]
                  state           <= ST_IDLE;
                  if (attempt[1]) begin
                     inhibit <= 1'b1;                                        // [RULE_17]
                  end
                  if (attempt == 2'h3) begin
                     fault_lamp <= 1'b1;                                     // [RULE_18]
                  end
               end else if (!valid || motor_fault_i ||
                            timer == TIMER_W'(SHIFT_T - 1)) begin            // [RULE_13] [RULE_08]
                  motor_to_high_o <= 1'b0;
                  motor_to_low_o  <= 1'b0;
                  timer           <= '0;
                  if (attempt == 2'h3) begin
                     fault_lamp <= 1'b1;                                     // [RULE_18]
                     inhibit    <= 1'b1;
                     state      <= ST_IDLE;
                  end else begin
                     attempt <= attempt + 1'b1;                              // [RULE_17]
                     state   <= ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               timer <= timer + 1'b1;
               if (timer == TIMER_W'(RETRY_T - 1)) begin                     // [RULE_17] [RULE_18]
                  timer <= '0;
                  state <= ST_DRIVE;
               end
            end
            default: begin
               state <= ST_OFF;
            end
         endcase
      end
   end

   // ***************************************************************
   // switch history and lamps
   // ***************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_prev <= 1'b0;
      end else begin
         sw_prev <= range_select_switch_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blink_cnt <= '0;
         blink_ph  <= 1'b0;
      end else if (!blinking) begin
         blink_cnt <= '0;
         blink_ph  <= 1'b1;
      end else if (blink_cnt == TIMER_W'(BLINK_T - 1)) begin                 // [RULE_15]
         blink_cnt <= '0;
         blink_ph  <= ~blink_ph;
      end else begin
         blink_cnt <= blink_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_range_lamp_o  <= 1'b0;
         fault_lamp_o      <= 1'b0;
         shift_inhibited_o <= 1'b0;
      end else begin
         shift_inhibited_o <= inhibit;
         if (state == ST_BULB) begin
            low_range_lamp_o <= 1'b1;                                        // [RULE_01]
            fault_lamp_o     <= 1'b1;
         end else begin
            low_range_lamp_o <= blinking ? blink_ph : lamp_steady;           // [RULE_15] [RULE_16]
            fault_lamp_o     <= fault_lamp;
         end
      end
   end

   // ***************************************************************
   // front clutch coil PWM
   // ***************************************************************
   logic [3:0]       tick_cnt;
   logic [6:0]       pwm_cnt;
   logic [6:0]       duty;
   logic [6:0]       boost;
   logic [6:0]       base_duty;
   logic [RPM_W-1:0] slip;
   logic             in_low;

   assign in_low    = enc_low_side(encoder_i) && valid;
   assign slip      = (front_rpm_i > rear_rpm_i) ? front_rpm_i - rear_rpm_i
                                                 : rear_rpm_i - front_rpm_i;
   assign base_duty = 7'(throttle_position_i[7:3]) + 7'(rear_rpm_i[11:7]);   // [RULE_19]

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt <= '0;
         pwm_cnt  <= '0;
      end else if (tick_cnt == 4'(PWM_TICK_CYC - 1)) begin
         tick_cnt <= '0;
         pwm_cnt  <= (pwm_cnt == PWM_STEPS - 7'h01) ? 7'h00 : pwm_cnt + 7'h01;
      end else begin
         tick_cnt <= tick_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         duty  <= '0;
         boost <= '0;
      end else if (tick_cnt == 4'h0 && pwm_cnt == 7'h00) begin
         if (slip > SLIP_RPM_LIMIT) begin                                   // [RULE_20]
            boost <= (boost + DUTY_STEP > DUTY_MAX) ? DUTY_MAX : boost + DUTY_STEP;
         end else begin
            boost <= '0;
         end
         if (antilock_brake_active_i) begin
            duty <= DUTY_ABS;                                                // [RULE_21]
         end else if (in_low && (front_rpm_i > LOW_RPM_MAX || rear_rpm_i > LOW_RPM_MAX)) begin
            duty <= DUTY_MAX;                                                // [RULE_22]
         end else if ({1'b0, base_duty} + {1'b0, boost} > {1'b0, DUTY_MAX}) begin
            duty <= DUTY_MAX;
         end else begin
            duty <= base_duty + boost;                                       // [RULE_19] [RULE_20]
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         front_clutch_coil_o <= 1'b0;
      end else begin
         front_clutch_coil_o <= (pwm_cnt < duty);
      end
   end
endmodule // transfer_range_shift_torque_ctrl
`default_nettype wire

// ==== dv/range_ctrl_props.sv ====
/* Assertions on the range controller top ports.
   Assumes binding into the design top, one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module range_ctrl_props
   import range_ctrl_pkg::*;
#(
   parameter int unsigned SHIFT_T   = SHIFT_CYC,
   parameter int unsigned NEUTRAL_T = NEUTRAL_CYC
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        ignition_i,
   input wire logic [3:0]  encoder_i,
   input wire logic        neutral_i,
   input wire logic [11:0] front_rpm_i,
   input wire logic [11:0] rear_rpm_i,
   input wire logic        motor_to_high_o,
   input wire logic        motor_to_low_o,
   input wire logic        low_range_lamp_o,
   input wire logic        fault_lamp_o,
   input wire logic        shift_inhibited_o
);
   // ***************************************************************
   // helper counters
   // ***************************************************************
   logic        run;
   logic        fresh;
   logic        retry;
   int unsigned mcnt;
   int unsigned qcnt;
   assign run = motor_to_high_o || motor_to_low_o;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mcnt  <= 0;
         qcnt  <= 0;
         fresh <= 1'b1;
         retry <= 1'b0;
      end else begin
         // set when a drive ended off its goal code
         if (run) retry <= (encoder_i != (motor_to_low_o ? ENC_LOW : ENC_HIGH));
         mcnt  <= run ? mcnt + 1 : 0;
         qcnt  <= (neutral_i && front_rpm_i < SHIFT_RPM_MAX && rear_rpm_i < SHIFT_RPM_MAX)
                  ? qcnt + 1 : 0;
         fresh <= fresh && !ignition_i;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_motor_one_way: assert property (!(motor_to_high_o && motor_to_low_o))
      else $error("motor driven both ways");
   a_goal_high_stop: assert property (motor_to_high_o && encoder_i == ENC_HIGH |=> !run)
      else $error("motor kept on at high");
   a_goal_low_stop: assert property (motor_to_low_o && encoder_i == ENC_LOW |=> !run)
      else $error("motor kept on at low");
   a_invalid_stops: assert property (run && !enc_valid(encoder_i) |=> !run)
      else $error("motor kept on with invalid code");
   a_shift_timeout: assert property (mcnt <= SHIFT_T + 1)
      else $error("motor on too long");
   a_inhibit_holds: assert property (shift_inhibited_o && !run |=> !run)
      else $error("motor started while inhibited");
   a_bulb_check: assert property (fresh && ignition_i |-> ##4 (low_range_lamp_o && fault_lamp_o) [*8])
      else $error("bulb check lamps missing");
   a_qual_first: assert property ($rose(run) && !retry |-> $past(qcnt) >= NEUTRAL_T)
      else $error("motor started before qualification");
   a_lamp_low_end: assert property (motor_to_low_o && encoder_i == ENC_LOW |-> ##3 low_range_lamp_o)
      else $error("low lamp off after low shift");
   a_lamp_high_end: assert property (motor_to_high_o && encoder_i == ENC_HIGH |-> ##3 !low_range_lamp_o)
      else $error("low lamp on after high shift");
   c_shift_low: cover property ($rose(motor_to_low_o));
   c_inhibit: cover property ($rose(shift_inhibited_o));
   c_fault_inhibit: cover property (shift_inhibited_o && fault_lamp_o);
endmodule // range_ctrl_props
`default_nettype wire

// ==== dv/motor_encoder_model.sv ====
/* Shift motor with position encoder; one step per STEP_T driven cycles.
   Assumes the bench commands stalls and invalid codes. */
`timescale 1ns/1ps
`default_nettype none
module motor_encoder_model
   import range_ctrl_pkg::*;
#(
   parameter int unsigned STEP_T = 3
) (
   input wire logic  clk_i,
   input wire logic  to_high_i,
   input wire logic  to_low_i,
   input wire logic  stall_i,
   input wire logic  glitch_i,
   output logic [3:0] encoder_o
);
   // ***************************************************************
   // position and code
   // ***************************************************************
   logic [2:0]  pos = 3'h2;
   int unsigned cnt = 0;
   always_ff @(posedge clk_i) begin
      if ((to_high_i || to_low_i) && !stall_i) begin
         cnt <= (cnt == STEP_T - 1) ? 0 : cnt + 1;
         if (cnt == STEP_T - 1 && to_low_i && pos != 3'h7) pos <= pos + 3'h1;
         if (cnt == STEP_T - 1 && to_high_i && pos != 3'h0) pos <= pos - 3'h1;
      end
   end
   always_comb begin
      case (pos)
         3'h0: encoder_o = ENC_LEFT_STOP;
         3'h1: encoder_o = ENC_LEFT_HIGH;
         3'h2: encoder_o = ENC_HIGH;
         3'h3: encoder_o = ENC_RIGHT_HIGH;
         3'h4: encoder_o = ENC_NEUTRAL;
         3'h5: encoder_o = ENC_ZONE2;
         3'h6: encoder_o = ENC_LOW;
         default: encoder_o = ENC_RIGHT_STOP;
      endcase
      if (glitch_i) encoder_o = 4'h7;
   end
endmodule // motor_encoder_model
`default_nettype wire

// ==== dv/tb_top.sv ====
/* Self-checking bench for the range controller.
   Assumes the motor model on the encoder and short timing parameters. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %0h got %0h", what, e, g); end end
module tb_top;
   import range_ctrl_pkg::*;
   // ***************************************************************
   // signals and design
   // ***************************************************************
   logic        clk_i = 1'b0, rst_n_i = 1'b0, ign = 1'b1, sw = 1'b1, neu = 1'b0;
   logic        abs_a = 1'b0, mfault = 1'b0, sfault = 1'b0, stall = 1'b0, glitch = 1'b0;
   logic [11:0] front = 12'h000, rear = 12'h000;
   logic [7:0]  thr = 8'h00;
   logic [3:0]  enc;
   logic        hi, lo, lamp, flamp, inh, coil;
   int          error_cnt = 0, comparisons = 0, n, x, i;
   always #50 clk_i = ~clk_i;
   transfer_range_shift_torque_ctrl #(.BULB_T(20), .BLINK_T(10), .NEUTRAL_T(30), .SHIFT_T(60),
      .RETRY_T(40)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ignition_i(ign), .encoder_i(enc),
      .range_select_switch_i(sw), .neutral_i(neu), .front_rpm_i(front), .rear_rpm_i(rear),
      .throttle_position_i(thr), .antilock_brake_active_i(abs_a), .motor_fault_i(mfault),
      .speed_sensor_fault_i(sfault), .motor_to_high_o(hi), .motor_to_low_o(lo),
      .low_range_lamp_o(lamp), .fault_lamp_o(flamp), .shift_inhibited_o(inh),
      .front_clutch_coil_o(coil));
   motor_encoder_model u_motor (.clk_i(clk_i), .to_high_i(hi), .to_low_i(lo), .stall_i(stall),
      .glitch_i(glitch), .encoder_o(enc));
   task automatic tick(input int k); repeat (k) @(posedge clk_i); endtask
   task automatic wait_run(input logic on, input int lim);
      for (int j = 0; j < lim && (hi || lo) !== on; j++) @(posedge clk_i);
      `CHK("motor", on, hi || lo)
   endtask
   task automatic quiet(input int k);
      n = 0;
      repeat (k) begin @(posedge clk_i); if ((hi || lo) !== 1'b0) n++; end
      `CHK("motor idle", 0, n)
   endtask
   task automatic measure; // high cycles over one settled pwm period
      tick(2500);
      n = 0;
      repeat (1000) begin @(posedge clk_i); if (coil === 1'b1) n++; end
   endtask
   function automatic int base_duty(input logic [7:0] t, input logic [11:0] r);
      int d;
      d = t[7:3] + r[11:7];
      return (d > DUTY_MAX ? DUTY_MAX : d) * 10;
   endfunction
   task automatic conclude;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      error_cnt++;
      conclude();
   end
   initial begin
      x = $urandom(32'hb276aa34);
      tick(8); rst_n_i <= 1'b1;
      tick(6); `CHK("bulb lamp", 1'b1, lamp && flamp)
      tick(30); n = 0;
      repeat (60) begin @(posedge clk_i); if (lamp === 1'b1) n++; end
      `CHK("blink", 1'b1, n >= 20 && n <= 40)
      neu <= 1'b1; wait_run(1'b1, 60); `CHK("to low", 1'b1, lo)
      wait_run(1'b0, 100); tick(3); `CHK("enc", ENC_LOW, enc)
      `CHK("lamp low", 1'b1, lamp)
      x = 176 + $urandom % 200; front <= 12'(x); rear <= 12'(x);
      measure(); `CHK("duty low", 880, n)
      sw <= 1'b0; quiet(60);
      x = $urandom % 87; front <= 12'(x); rear <= 12'(x);
      wait_run(1'b1, 50); `CHK("to high", 1'b1, hi)
      tick(2); sw <= 1'b1; neu <= 1'b0; tick(2); sw <= 1'b0;
      wait_run(1'b0, 100); neu <= 1'b1; tick(3); `CHK("enc", ENC_HIGH, enc)
      `CHK("lamp high", 1'b0, lamp)
      abs_a <= 1'b1; measure(); `CHK("duty abs", 300, n)
      abs_a <= 1'b0; thr <= 8'($urandom % 128); x = $urandom % 2048;
      front <= 12'(x); rear <= 12'(x);
      measure(); `CHK("duty base", base_duty(thr, rear), n)
      front <= rear + 12'h064; measure(); `CHK("slip", 1'b1, n > base_duty(thr, rear))
      front <= rear; measure(); `CHK("duty back", base_duty(thr, rear), n)
      front <= 12'h000; rear <= 12'h000;
      for (i = 0; i < 3; i++) begin
         glitch <= (i == 0); mfault <= (i == 1); sfault <= (i == 2); tick(2);
         sw <= 1'b1; quiet(80); sw <= 1'b0; tick(2);
         glitch <= 1'b0; mfault <= 1'b0; sfault <= 1'b0; tick(2);
      end
      sw <= 1'b1; wait_run(1'b1, 60); tick(2); glitch <= 1'b1; stall <= 1'b1;
      tick(2); `CHK("invalid stop", 1'b0, hi || lo)
      glitch <= 1'b0; wait_run(1'b1, 60); `CHK("retry", 1'b1, lo)
      wait_run(1'b0, 80); wait_run(1'b1, 60); `CHK("return", 1'b1, hi)
      stall <= 1'b0; wait_run(1'b0, 100); tick(3);
      `CHK("inhibit", 1'b1, inh)
      `CHK("no fault", 1'b0, flamp)
      sw <= 1'b0; tick(3); sw <= 1'b1; quiet(80);
      ign <= 1'b0; tick(10); ign <= 1'b1; tick(6);
      `CHK("inhibit clear", 1'b0, inh)
      `CHK("bulb again", 1'b1, lamp && flamp)
      wait_run(1'b1, 80); wait_run(1'b0, 100); `CHK("enc", ENC_LOW, enc)
      sw <= 1'b0; wait_run(1'b1, 60); tick(4); stall <= 1'b1;
      for (i = 0; i < 800 && inh !== 1'b1; i++) @(posedge clk_i);
      tick(3); `CHK("fail inhibit", 1'b1, inh && flamp)
      `CHK("motor off", 1'b0, hi || lo)
      stall <= 1'b0; ign <= 1'b0; tick(10); ign <= 1'b1; wait_run(1'b1, 80);
      `CHK("power-up high", 1'b1, hi)
      wait_run(1'b0, 100); `CHK("enc", ENC_HIGH, enc)
      ign <= 1'b0; tick(10); ign <= 1'b1; tick(30); quiet(60);
      `CHK("match lamp", 1'b0, lamp)
      conclude();
   end
endmodule // tb_top
bind transfer_range_shift_torque_ctrl range_ctrl_props #(.SHIFT_T(SHIFT_T),
   .NEUTRAL_T(NEUTRAL_T)) u_props (.clk_i, .rst_n_i, .ignition_i, .encoder_i, .neutral_i,
   .front_rpm_i, .rear_rpm_i, .motor_to_high_o, .motor_to_low_o, .low_range_lamp_o,
   .fault_lamp_o, .shift_inhibited_o);
`default_nettype wire
